/* rtl/abps_defines.svh */
// Offsets, field widths, reset values and timing figures of the auxiliary pin selector.
`ifndef ABPS_DEFINES_SVH
`define ABPS_DEFINES_SVH

`define ABPS_ADDR_W           4
`define ABPS_DATA_W           32
`define ABPS_OFS_GPIO_DIR     4'h0
`define ABPS_OFS_GPIO_OUT     4'h4
`define ABPS_OFS_GPIO_IN      4'h8
`define ABPS_OFS_PIN_SEL      4'hC

`define ABPS_SEL_W            4
`define ABPS_SEL_RESET        4'h9
`define ABPS_GPIO_DIR_RESET   8'h00
`define ABPS_GPIO_OUT_RESET   8'h00

`define ABPS_CORE_CLK_KHZ     200000
`define ABPS_CLK_HIGH_KHZ     30000
`define ABPS_CLK_MID_KHZ      15000
`define ABPS_CLK_LOW_KHZ      7500
`define ABPS_NCO_W            16

`define ABPS_LED_STRETCH_US   50
`define ABPS_LED_STRETCH_CYC  ((`ABPS_LED_STRETCH_US * `ABPS_CORE_CLK_KHZ) / 1000)

`endif

/* rtl/abps_pkg.sv */
// Types shared by the auxiliary pin selector: the per-pin function codes.
package abps_pkg;

    // Codes follow the order of the options, starting at zero.
    typedef enum logic [3:0] {
        ABPS_FN_RS485_DE,
        ABPS_FN_PWR_EN_N,
        ABPS_FN_TX_LED_N,
        ABPS_FN_RX_LED_N,
        ABPS_FN_ANY_LED_N,
        ABPS_FN_SLEEP_N,
        ABPS_FN_CLK_HIGH,
        ABPS_FN_CLK_MID,
        ABPS_FN_CLK_LOW,
        ABPS_FN_PULLED_UP,
        ABPS_FN_DRIVE_1,
        ABPS_FN_DRIVE_0,
        ABPS_FN_GPIO
    } abps_func_t;

    // Codes past the last option fall back to the safe pulled-up input.
    function automatic abps_func_t abps_decode(input logic [3:0] code);
        abps_func_t f;
        f = ABPS_FN_PULLED_UP;
        if (code <= 4'(ABPS_FN_GPIO)) begin
            f = abps_func_t'(code);
        end
        return f;
    endfunction : abps_decode

endpackage : abps_pkg

/* rtl/abps_top.sv */
// Auxiliary control bus pin function selector with bit-bang GPIO registers.
`include "abps_defines.svh"

// What this block does
// - RS485 drive-enable pin is high exactly while the UART transmits.
// - Power-enable pin lets external level shifters drop to low current in suspend.
// - Active-low power-enable is high in USB suspend, low in normal operation.
// - Transmit LED pin pulses low whenever data is transmitted.
// - Receive LED pin pulses low whenever data is received.
// - Combined LED pin pulses low on transmission or reception.
// - Suspend indicator pin is driven low for as long as the USB interface is suspended.
// - Clock options drive 30, 15 or 7.5 MHz derived from the core clock.
// - Static options: pulled-up unused input, constant high, constant low.
// - I/O option makes the pin a bit-bang pin under software direction and value.
// - Each pin is independently assignable as GPIO without touching the others.
// - GPIO pins work at the same time as the UART, up to PIN_COUNT pins (four by default, at most eight).
// - Each pin function comes from configuration memory bits, one option per pin.
module abps_top #(
    parameter int PIN_COUNT          = 4,                       // Auxiliary pins served.
    parameter int LED_CNT_W          = 24,                      // Width of the LED stretch counters.
    parameter int LED_STRETCH_CYCLES = `ABPS_LED_STRETCH_CYC    // Minimum LED flash in core cycles.
) (
    input  wire logic                          clk_i,            // 200 MHz core clock.
    input  wire logic                          reset_n_i,        // Asynchronous reset, active low.
    input  wire logic                          cfg_load_i,       // Pulse: latch pin selections.
    input  wire logic [PIN_COUNT*`ABPS_SEL_W-1:0] cfg_select_i,  // Selection codes from config memory.
    input  wire logic                          uart_tx_active_i, // UART is shifting out a frame.
    input  wire logic                          tx_data_pulse_i,  // Pulse per transmitted byte.
    input  wire logic                          rx_data_pulse_i,  // Pulse per received byte.
    input  wire logic                          usb_suspend_i,    // USB interface is suspended.
    input  wire logic [`ABPS_ADDR_W-1:0]       reg_addr_i,       // Register byte address.
    input  wire logic [`ABPS_DATA_W-1:0]       reg_wdata_i,      // Register write data.
    input  wire logic                          reg_wr_i,         // Write strobe.
    input  wire logic                          reg_rd_i,         // Read strobe.
    output logic      [`ABPS_DATA_W-1:0]       reg_rdata_o,      // Read data, cycle after the strobe.
    input  wire logic [PIN_COUNT-1:0]          pad_in_i,         // Pin levels from the pads.
    output logic      [PIN_COUNT-1:0]          pad_out_o,        // Pin output values.
    output logic      [PIN_COUNT-1:0]          pad_oe_o,         // Pin output enables, high drives.
    output logic      [PIN_COUNT-1:0]          pad_pullup_o      // Pin pull-up enables.
);
    import abps_pkg::*;

    localparam logic [LED_CNT_W-1:0] LED_LOAD = LED_CNT_W'(LED_STRETCH_CYCLES);
    localparam int                   NCO_MSB  = `ABPS_NCO_W - 1;

    // Out-of-range parameters stop elaboration rather than leave registers wrongly sized.
    if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : g_bad_pin_count
        $error("PIN_COUNT must lie between 1 and 8");
    end
    if (LED_STRETCH_CYCLES < 1 || LED_STRETCH_CYCLES >= (1 << LED_CNT_W)) begin : g_bad_stretch
        $error("LED_STRETCH_CYCLES does not fit the stretch counter");
    end

    // Phase step of a numerically controlled divider for a given output rate.
    function automatic logic [`ABPS_NCO_W-1:0] nco_step(input longint khz);
        longint s;
        s = (khz << `ABPS_NCO_W) / `ABPS_CORE_CLK_KHZ;
        return s[`ABPS_NCO_W-1:0];
    endfunction : nco_step

    // Load on activity, otherwise count down to zero.
    function automatic logic [LED_CNT_W-1:0] stretch_next(input logic [LED_CNT_W-1:0] cnt,
                                                         input logic                 evt);
        logic [LED_CNT_W-1:0] n;
        n = cnt;
        if (evt) begin
            n = LED_LOAD;
        end else if (cnt != '0) begin
            n = cnt - 1'b1;
        end
        return n;
    endfunction : stretch_next

    abps_func_t                  sel_reg [PIN_COUNT];
    logic [PIN_COUNT-1:0]        gpio_dir_reg;
    logic [PIN_COUNT-1:0]        gpio_out_reg;
    logic [PIN_COUNT-1:0]        sync1_reg;
    logic [PIN_COUNT-1:0]        sync2_reg;
    logic [PIN_COUNT-1:0]        sync3_reg;
    logic [PIN_COUNT-1:0]        pin_state_reg;
    logic [LED_CNT_W-1:0]        tx_led_cnt_reg;
    logic [LED_CNT_W-1:0]        rx_led_cnt_reg;
    logic [LED_CNT_W-1:0]        any_led_cnt_reg;
    logic [`ABPS_NCO_W-1:0]      nco_reg [3];
    logic [`ABPS_NCO_W-1:0]      nco_inc [3];
    logic [PIN_COUNT-1:0]        pad_out_next;
    logic [PIN_COUNT-1:0]        pad_oe_next;
    logic [PIN_COUNT-1:0]        pad_pullup_next;
    logic [PIN_COUNT*`ABPS_SEL_W-1:0] sel_flat;

    assign nco_inc[0] = nco_step(`ABPS_CLK_HIGH_KHZ);
    assign nco_inc[1] = nco_step(`ABPS_CLK_MID_KHZ);
    assign nco_inc[2] = nco_step(`ABPS_CLK_LOW_KHZ);

    // Selections change only on a load strobe from the configuration loader.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int p = 0; p < PIN_COUNT; p++) begin
                sel_reg[p] <= abps_func_t'(`ABPS_SEL_RESET);
            end
        end else if (cfg_load_i) begin
            for (int p = 0; p < PIN_COUNT; p++) begin
                sel_reg[p] <= abps_decode(cfg_select_i[p*`ABPS_SEL_W +: `ABPS_SEL_W]);
            end
        end
    end

    // Software direction and value registers cover every pin but act only on pins selected as GPIO, so pins never interfere.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gpio_dir_reg <= PIN_COUNT'(`ABPS_GPIO_DIR_RESET);
            gpio_out_reg <= PIN_COUNT'(`ABPS_GPIO_OUT_RESET);
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ABPS_OFS_GPIO_DIR) begin
                gpio_dir_reg <= reg_wdata_i[PIN_COUNT-1:0];
            end
            if (reg_addr_i == `ABPS_OFS_GPIO_OUT) begin
                gpio_out_reg <= reg_wdata_i[PIN_COUNT-1:0];
            end
        end
    end

    // Pads are asynchronous; a level is accepted once the second and third stages agree.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg     <= '0;
            sync2_reg     <= '0;
            sync3_reg     <= '0;
            pin_state_reg <= '0;
        end else begin
            sync1_reg     <= pad_in_i;
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync2_reg;
            pin_state_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) |
                             (pin_state_reg & (sync2_reg ^ sync3_reg));
        end
    end

    // A short burst would flash too briefly to see, hence the stretch counters.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_led_cnt_reg  <= '0;
            rx_led_cnt_reg  <= '0;
            any_led_cnt_reg <= '0;
        end else begin
            tx_led_cnt_reg  <= stretch_next(tx_led_cnt_reg, tx_data_pulse_i);
            rx_led_cnt_reg  <= stretch_next(rx_led_cnt_reg, rx_data_pulse_i);
            any_led_cnt_reg <= stretch_next(any_led_cnt_reg, tx_data_pulse_i | rx_data_pulse_i);
        end
    end

    // 200 MHz does not divide to 30 MHz evenly, so the output edges carry one cycle of jitter.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int k = 0; k < 3; k++) begin
                nco_reg[k] <= '0;
            end
        end else begin
            for (int k = 0; k < 3; k++) begin
                nco_reg[k] <= nco_reg[k] + nco_inc[k];
            end
        end
    end

    // Each pin decodes its own selection; the case gives exactly one option per pin.
    always_comb begin
        pad_out_next    = '0;
        pad_oe_next     = '0;
        pad_pullup_next = '0;
        for (int p = 0; p < PIN_COUNT; p++) begin
            pad_oe_next[p] = 1'b1;
            case (sel_reg[p])
                ABPS_FN_RS485_DE: begin
                    pad_out_next[p] = uart_tx_active_i;
                end
                ABPS_FN_PWR_EN_N: begin
                    pad_out_next[p] = usb_suspend_i;
                end
                ABPS_FN_TX_LED_N: begin
                    pad_out_next[p] = (tx_led_cnt_reg == '0);
                end
                ABPS_FN_RX_LED_N: begin
                    pad_out_next[p] = (rx_led_cnt_reg == '0);
                end
                ABPS_FN_ANY_LED_N: begin
                    pad_out_next[p] = (any_led_cnt_reg == '0);
                end
                ABPS_FN_SLEEP_N: begin
                    pad_out_next[p] = ~usb_suspend_i;
                end
                ABPS_FN_CLK_HIGH: begin
                    pad_out_next[p] = nco_reg[0][NCO_MSB];
                end
                ABPS_FN_CLK_MID: begin
                    pad_out_next[p] = nco_reg[1][NCO_MSB];
                end
                ABPS_FN_CLK_LOW: begin
                    pad_out_next[p] = nco_reg[2][NCO_MSB];
                end
                ABPS_FN_DRIVE_1: begin
                    pad_out_next[p] = 1'b1;
                end
                ABPS_FN_DRIVE_0: begin
                    pad_out_next[p] = 1'b0;
                end
                ABPS_FN_GPIO: begin
                    pad_out_next[p] = gpio_out_reg[p];
                    pad_oe_next[p]  = gpio_dir_reg[p];
                end
                default: begin
                    pad_oe_next[p]     = 1'b0;
                    pad_pullup_next[p] = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pad_out_o    <= '0;
            pad_oe_o     <= '0;
            pad_pullup_o <= '1;
        end else begin
            pad_out_o    <= pad_out_next;
            pad_oe_o     <= pad_oe_next;
            pad_pullup_o <= pad_pullup_next;
        end
    end

    always_comb begin
        sel_flat = '0;
        for (int p = 0; p < PIN_COUNT; p++) begin
            sel_flat[p*`ABPS_SEL_W +: `ABPS_SEL_W] = sel_reg[p];
        end
    end

    // Read data stand for one cycle only; unmapped offsets read as zero.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= '0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `ABPS_OFS_GPIO_DIR: reg_rdata_o <= `ABPS_DATA_W'(gpio_dir_reg);
                    `ABPS_OFS_GPIO_OUT: reg_rdata_o <= `ABPS_DATA_W'(gpio_out_reg);
                    `ABPS_OFS_GPIO_IN:  reg_rdata_o <= `ABPS_DATA_W'(pin_state_reg);
                    `ABPS_OFS_PIN_SEL:  reg_rdata_o <= `ABPS_DATA_W'(sel_flat);
                    default:            reg_rdata_o <= '0;
                endcase
            end
        end
    end

    property p_led_load;
        @(posedge clk_i) disable iff (!reset_n_i)
        tx_data_pulse_i |=> (tx_led_cnt_reg == LED_LOAD);
    endproperty
    a_led_load: assert property (p_led_load) else $error("TX LED stretch not reloaded");

    property p_led_count;
        @(posedge clk_i) disable iff (!reset_n_i)
        (!rx_data_pulse_i && rx_led_cnt_reg != '0) |=> (rx_led_cnt_reg == $past(rx_led_cnt_reg) - 1'b1);
    endproperty
    a_led_count: assert property (p_led_count) else $error("RX LED stretch miscounted");

    property p_sync_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        (sync2_reg == sync3_reg) |=> (pin_state_reg == $past(sync3_reg));
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("Agreed pin level not taken");

    property p_rd_once;
        @(posedge clk_i) disable iff (!reset_n_i)
        !reg_rd_i |=> (reg_rdata_o == '0);
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("Read data outside the answer cycle");

    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_chk
        property p_rs485;
            @(posedge clk_i) disable iff (!reset_n_i)
            (sel_reg[g] == ABPS_FN_RS485_DE) |=> (pad_oe_o[g] && pad_out_o[g] == $past(uart_tx_active_i));
        endproperty
        a_rs485: assert property (p_rs485) else $error("Drive enable does not follow transmit");

        property p_pwr;
            @(posedge clk_i) disable iff (!reset_n_i)
            (sel_reg[g] == ABPS_FN_PWR_EN_N) |=> (pad_out_o[g] == $past(usb_suspend_i));
        endproperty
        a_pwr: assert property (p_pwr) else $error("Power enable wrong for suspend state");

        property p_tx_led;
            @(posedge clk_i) disable iff (!reset_n_i)
            (tx_data_pulse_i && sel_reg[g] == ABPS_FN_TX_LED_N) ##1 (sel_reg[g] == ABPS_FN_TX_LED_N)
                |=> !pad_out_o[g];
        endproperty
        a_tx_led: assert property (p_tx_led) else $error("TX LED did not pulse low");

        property p_rx_led;
            @(posedge clk_i) disable iff (!reset_n_i)
            (rx_data_pulse_i && sel_reg[g] == ABPS_FN_RX_LED_N) ##1 (sel_reg[g] == ABPS_FN_RX_LED_N)
                |=> !pad_out_o[g];
        endproperty
        a_rx_led: assert property (p_rx_led) else $error("RX LED did not pulse low");

        property p_any_led;
            @(posedge clk_i) disable iff (!reset_n_i)
            ((tx_data_pulse_i || rx_data_pulse_i) && sel_reg[g] == ABPS_FN_ANY_LED_N) ##1
                (sel_reg[g] == ABPS_FN_ANY_LED_N) |=> !pad_out_o[g];
        endproperty
        a_any_led: assert property (p_any_led) else $error("Combined LED did not pulse low");

        property p_sleep;
            @(posedge clk_i) disable iff (!reset_n_i)
            (sel_reg[g] == ABPS_FN_SLEEP_N && usb_suspend_i) |=> (pad_oe_o[g] && !pad_out_o[g]);
        endproperty
        a_sleep: assert property (p_sleep) else $error("Suspend indicator not low");

        property p_static;
            @(posedge clk_i) disable iff (!reset_n_i)
            (sel_reg[g] == ABPS_FN_PULLED_UP) |=> (!pad_oe_o[g] && pad_pullup_o[g]);
        endproperty
        a_static: assert property (p_static) else $error("Unused input not released with pull-up");

        property p_gpio;
            @(posedge clk_i) disable iff (!reset_n_i)
            (sel_reg[g] == ABPS_FN_GPIO) |=> (pad_oe_o[g] == $past(gpio_dir_reg[g]) &&
                                               pad_out_o[g] == $past(gpio_out_reg[g]));
        endproperty
        a_gpio: assert property (p_gpio) else $error("GPIO pin ignores software control");

        property p_sel_fallback;
            @(posedge clk_i) disable iff (!reset_n_i)
            (cfg_load_i && cfg_select_i[g*`ABPS_SEL_W +: `ABPS_SEL_W] > 4'(ABPS_FN_GPIO))
                |=> (sel_reg[g] == ABPS_FN_PULLED_UP);
        endproperty
        a_sel_fallback: assert property (p_sel_fallback) else $error("Unknown code not made an input");
    end

endmodule : abps_top

/* tb/abps_pad_model.sv */
// Board-side model of the auxiliary pins: external drivers, pull-ups and floating lines.
module abps_pad_model #(
    parameter int PIN_COUNT = 4                      // Auxiliary pins modelled.
) (
    input  wire logic                 clk_i,        // Core clock, used to vary floating lines.
    input  wire logic [PIN_COUNT-1:0] pad_out_i,    // Values driven by the device.
    input  wire logic [PIN_COUNT-1:0] pad_oe_i,     // Device output enables.
    input  wire logic [PIN_COUNT-1:0] pad_pullup_i, // Device pull-up enables.
    input  wire logic [PIN_COUNT-1:0] ext_en_i,     // External circuit drives the pin.
    input  wire logic [PIN_COUNT-1:0] ext_val_i,    // Level driven by the external circuit.
    output logic      [PIN_COUNT-1:0] pad_level_o   // Resolved level seen at each pin.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [PIN_COUNT-1:0] float_pat;

    // A floating line must not look stable, so it toggles every cycle.
    initial float_pat = '0;
    always @(posedge clk_i) float_pat <= ~float_pat;

    always_comb begin
        for (int p = 0; p < PIN_COUNT; p++) begin
            if (pad_oe_i[p]) begin
                pad_level_o[p] = pad_out_i[p];
            end else if (ext_en_i[p]) begin
                pad_level_o[p] = ext_val_i[p];
            end else if (pad_pullup_i[p]) begin
                pad_level_o[p] = 1'b1;
            end else begin
                pad_level_o[p] = float_pat[p];
            end
        end
    end
endmodule : abps_pad_model

/* tb/abps_top_bench.sv */
// Self-checking bench for the auxiliary pin function selector.
`include "abps_defines.svh"
module abps_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import abps_pkg::*;
    localparam int LED = 8;
    logic clk_i = 0, reset_n_i = 0, cfg_load_i = 0, uart_tx_active_i = 0;
    logic tx_data_pulse_i = 0, rx_data_pulse_i = 0, usb_suspend_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic [15:0] cfg_select_i = '0;
    logic [3:0]  reg_addr_i = '0, pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o;
    logic [3:0]  ext_en = '0, ext_val = '0;
    logic [31:0] reg_wdata_i = '0, reg_rdata_o, rd_val;
    int n_fail = 0, num_checks = 0;

    always #2.5 clk_i = ~clk_i;

    abps_top #(.PIN_COUNT(4), .LED_CNT_W(24), .LED_STRETCH_CYCLES(LED)) i_abps_top (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_load_i(cfg_load_i), .cfg_select_i(cfg_select_i),
        .uart_tx_active_i(uart_tx_active_i), .tx_data_pulse_i(tx_data_pulse_i),
        .rx_data_pulse_i(rx_data_pulse_i), .usb_suspend_i(usb_suspend_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o));

    abps_pad_model #(.PIN_COUNT(4)) i_abps_pad_model (
        .clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pad_pullup_i(pad_pullup_o),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_level_o(pad_in_i));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wcyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wcyc

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe, so it is sampled just there.
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask : reg_read

    task automatic load_cfg(input logic [15:0] codes);
        @(posedge clk_i);
        cfg_load_i <= 1'b1;
        cfg_select_i <= codes;
        @(posedge clk_i);
        cfg_load_i <= 1'b0;
        wcyc(2);
    endtask : load_cfg

    task automatic pulse(input bit tx);
        @(posedge clk_i);
        if (tx) tx_data_pulse_i <= 1'b1;
        else rx_data_pulse_i <= 1'b1;
        @(posedge clk_i);
        tx_data_pulse_i <= 1'b0;
        rx_data_pulse_i <= 1'b0;
    endtask : pulse

    task automatic test_reset_state();
        chk("oe_after_reset", 32'h0, pad_oe_o);
        chk("pullup_after_reset", 32'hF, pad_pullup_o);
        reg_read(4'hC, rd_val);
        chk("sel_after_reset", 32'h9999, rd_val);
        reg_read(4'h0, rd_val);
        chk("dir_after_reset", 32'h0, rd_val);
    endtask : test_reset_state

    // Codes beyond the last option must leave the pin as a pulled-up input.
    task automatic test_bad_codes();
        load_cfg(16'hFEDC);
        reg_read(4'hC, rd_val);
        chk("sel_fallback", 32'h999C, rd_val);
        chk("fallback_pullup", 32'hE, pad_pullup_o);
    endtask : test_bad_codes

    task automatic test_static_power();
        load_cfg(16'hBA51);
        chk("static_oe", 32'hF, pad_oe_o);
        chk("awake_out", 32'h6, pad_out_o);
        @(posedge clk_i);
        usb_suspend_i <= 1'b1;
        wcyc(2);
        chk("suspend_out", 32'h5, pad_out_o);
        @(posedge clk_i);
        usb_suspend_i <= 1'b0;
        wcyc(2);
        chk("resume_out", 32'h6, pad_out_o);
    endtask : test_static_power

    task automatic test_gpio_with_uart();
        load_cfg(16'hCCC0);
        @(posedge clk_i);
        uart_tx_active_i <= 1'b1;
        reg_write(4'h0, 32'h3);
        reg_write(4'h4, 32'h2);
        reg_write(4'hC, 32'h0);
        ext_en <= 4'hC;
        ext_val <= 4'h8;
        wcyc(6);
        chk("gpio_oe", 32'h3, pad_oe_o);
        chk("gpio_out", 32'h3, pad_out_o & 4'h3);
        reg_read(4'h8, rd_val);
        chk("gpio_in", 32'hB, rd_val);
        reg_read(4'hC, rd_val);
        chk("sel_readonly", 32'hCCC0, rd_val);
        reg_read(4'h2, rd_val);
        chk("unmapped", 32'h0, rd_val);
        @(posedge clk_i);
        uart_tx_active_i <= 1'b0;
        wcyc(2);
        chk("de_idle", 32'h2, pad_out_o & 4'h3);
        ext_en <= 4'h0;
    endtask : test_gpio_with_uart

    task automatic test_leds();
        load_cfg(16'h9432);
        chk("leds_idle", 32'h7, pad_out_o & 4'h7);
        pulse(1);
        wcyc(2);
        chk("tx_flash", 32'h2, pad_out_o & 4'h7);
        wcyc(LED - 3);
        pulse(1);
        wcyc(LED - 2);
        chk("tx_retrigger", 32'h2, pad_out_o & 4'h7);
        wcyc(6);
        chk("tx_end", 32'h7, pad_out_o & 4'h7);
        pulse(0);
        wcyc(2);
        chk("rx_flash", 32'h1, pad_out_o & 4'h7);
        wcyc(LED + 3);
        chk("rx_end", 32'h7, pad_out_o & 4'h7);
    endtask : test_leds

    task automatic test_clocks();
        int rises[3];
        logic [3:0] last;
        load_cfg(16'h9876);
        rises = '{0, 0, 0};
        last = pad_out_o;
        for (int c = 0; c < 400; c++) begin
            wcyc(1);
            for (int p = 0; p < 3; p++) if (pad_out_o[p] && !last[p]) rises[p]++;
            last = pad_out_o;
        end
        chk("clk_high", 1, rises[0] >= 59 && rises[0] <= 61);
        chk("clk_mid", 1, rises[1] >= 29 && rises[1] <= 31);
        chk("clk_low", 1, rises[2] >= 14 && rises[2] <= 16);
        chk("clk_oe", 32'h7, pad_oe_o);
    endtask : test_clocks

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        wcyc(1);
        test_reset_state();
        test_bad_codes();
        test_static_power();
        test_gpio_with_uart();
        test_leds();
        test_clocks();
        test_done();
    end

    // Watchdog: a hang counts as a mismatch and closes the run.
    initial begin
        #200000;
        n_fail++;
        test_done();
    end
endmodule : abps_top_bench
